// File: bench/apcf_far_model.sv
// Far-side audio processor: master clock candidates and slave-mode clocks
`timescale 1ns/1ps
module apcf_far_model (
  output logic mclk_o,
  output logic rx_clk_o,
  output logic rxo_clk_o,
  output logic bit_o,
  output logic frame_o
);
  // ----------------
  // Free-running clocks, edges kept on the bench clock's falling edge
  // ----------------
  initial
  begin
    {mclk_o, rx_clk_o, rxo_clk_o, bit_o, frame_o} = 5'h00;
  end
  always #20 mclk_o = ~mclk_o;
  always #24 rx_clk_o = ~rx_clk_o;
  always #28 rxo_clk_o = ~rxo_clk_o;
  always #40 bit_o = ~bit_o;
  always #2560 frame_o = ~frame_o;
endmodule

// File: bench/apcf_top_sva.sv
// Port-level assertions for the audio port clock and format control block
`timescale 1ns/1ps
module apcf_top_sva #(
  parameter int ADR_W = 8
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic             port_a_frame_clock_o,
  input wire logic             port_a_bit_clock_o,
  input wire logic             port_a_frame_clock_oe_o,
  input wire logic             port_b_frame_clock_oe_o,
  input wire logic             port_b_serial_out_o
);
  // ----------------
  // Shadow of the control fields, taken from bus writes
  // ----------------
  logic       wr;
  logic [1:0] src_ff;
  logic       a_ms_ff;
  logic       b_ms_ff;
  logic       mute_ff;
  logic [2:0] idle_ff;

  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_ff  <= 2'h0;
      a_ms_ff <= 1'b0;
      b_ms_ff <= 1'b0;
      mute_ff <= 1'b0;
    end
    else if (wr && adr_i[7:2] == apcf_pkg::APCF_IDX_A_CLK)
      src_ff <= dat_i[3:2];
    else if (wr && adr_i[7:2] == apcf_pkg::APCF_IDX_A_MODE)
      a_ms_ff <= dat_i[0];
    else if (wr && adr_i[7:2] == apcf_pkg::APCF_IDX_B_FMT)
    begin
      b_ms_ff <= dat_i[3];
      mute_ff <= dat_i[6];
    end
  end

  // Generator off for seven cycles leaves slack for its own reset pipeline
  always_ff @(posedge clk_i)
  begin
    if (rst_i || ((a_ms_ff || b_ms_ff) && src_ff != 2'h3))
      idle_ff <= 3'h0;
    else if (idle_ff != 3'h7)
      idle_ff <= idle_ff + 3'h1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge held beyond one cycle");
  a_idle_zero: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside acknowledge");
  a_rsvd_zero:
    assert property (ack_o && !we_i && adr_i[7:2] == apcf_pkg::APCF_IDX_A_CLK |-> dat_o[31:4] == 28'h0)
    else $error("fixed-zero clock register bits read nonzero");
  a_mute_low:
    assert property (mute_ff && $past(mute_ff) |-> !port_b_serial_out_o)
    else $error("serial output high while muted");
  a_b_mode_oe:
    assert property (b_ms_ff == $past(b_ms_ff) |-> port_b_frame_clock_oe_o == b_ms_ff)
    else $error("port B clock drive differs from its mode bit");
  a_a_mode_oe:
    assert property (a_ms_ff == $past(a_ms_ff) |-> port_a_frame_clock_oe_o == a_ms_ff)
    else $error("port A clock drive differs from its mode bit");
  a_idle_clocks:
    assert property (idle_ff == 3'h7 |-> !port_a_frame_clock_o && !port_a_bit_clock_o)
    else $error("generated clocks run while generator is off");

  c_write: cover property (ack_o && we_i);
  c_frame: cover property ($rose(port_a_frame_clock_o));
  c_mute: cover property (mute_ff && port_b_frame_clock_oe_o);
endmodule

bind apcf_top apcf_top_sva #(.ADR_W(ADR_W)) apcf_top_sva_inst (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
  .port_a_frame_clock_o, .port_a_bit_clock_o, .port_a_frame_clock_oe_o,
  .port_b_frame_clock_oe_o, .port_b_serial_out_o
);

// File: bench/tb.sv
// Self-checking bench for the audio port clock and format control block
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sl_bit, sl_frame, sl_run;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        mclk_i, receiver_clock_in_i, recovered_receiver_clock_out_i;
  logic        port_a_frame_clock_i, port_a_frame_clock_o, port_a_frame_clock_oe_o;
  logic        port_a_bit_clock_i, port_a_bit_clock_o, port_a_bit_clock_oe_o;
  logic        port_b_frame_clock_i, port_b_frame_clock_o, port_b_frame_clock_oe_o;
  logic        port_b_bit_clock_i, port_b_bit_clock_o, port_b_bit_clock_oe_o;
  logic        port_b_in_valid_i, port_b_in_ready_o, port_a_in_valid_i, port_a_in_ready_o;
  logic        recv_valid_i, recv_ready_o, port_b_serial_out_o;
  int          n_fail, total_checks;
  apcf_pkg::apcf_sample_t port_b_in_data_i, port_a_in_data_i, recv_data_i;

  apcf_top apcf_top_inst (.*);
  apcf_far_model apcf_far_model_inst (.mclk_o(mclk_i), .rx_clk_o(receiver_clock_in_i),
    .rxo_clk_o(recovered_receiver_clock_out_i), .bit_o(sl_bit), .frame_o(sl_frame));

  // ----------------
  // Pins: the far side drives them only while the block leaves them free
  // ----------------
  assign port_a_frame_clock_i = port_a_frame_clock_oe_o ? port_a_frame_clock_o : sl_frame & sl_run;
  assign port_a_bit_clock_i = port_a_bit_clock_oe_o ? port_a_bit_clock_o : sl_bit & sl_run;
  assign port_b_frame_clock_i = port_b_frame_clock_oe_o ? port_b_frame_clock_o : sl_frame & sl_run;
  assign port_b_bit_clock_i = port_b_bit_clock_oe_o ? port_b_bit_clock_o : sl_bit & sl_run;

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
    if (n >= 20)
      hang();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(a, 1'b1, 4'h1, {24'h0, d}, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 4'h0, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic push(input logic [23:0] d);
    int n;
    @(posedge clk_i);
    port_b_in_valid_i <= 1'b1;
    port_b_in_data_i <= {1'b1, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (port_b_in_ready_o !== 1'b1 && n < 3000);
    port_b_in_valid_i <= 1'b0;
    if (n >= 3000)
      hang();
  endtask

  task automatic bframe();
    logic f;
    int n;
    f = port_b_frame_clock_i;
    for (n = 0; n < 3000 && port_b_frame_clock_i === f; n++)
      @(posedge clk_i);
    if (n >= 3000)
      hang();
  endtask

  // Frame period in bench cycles and bit clock rises inside one frame
  task automatic aclk(input logic [1:0] src, input logic [1:0] div, input int per);
    int n, ph, cyc, bits;
    logic pf, pb;
    wr(8'h10, {4'h0, src, div});
    ph = 0;
    cyc = 0;
    bits = 0;
    pf = port_a_frame_clock_o;
    pb = port_a_bit_clock_o;
    for (n = 0; n < 20000 && ph < 3; n++)
    begin
      @(posedge clk_i);
      cyc += (ph == 2);
      bits += (ph == 2 && port_a_bit_clock_o && !pb);
      ph += (port_a_frame_clock_o && !pf);
      pf = port_a_frame_clock_o;
      pb = port_a_bit_clock_o;
    end
    if (ph < 3)
      hang();
    chk(cyc, 128 * (div + 1) * per);
    chk(bits, 64);
  endtask

  task automatic ser(input logic [2:0] fmt, input logic mute, input logic ms,
                     input logic [23:0] w);
    logic [24:0] cap;
    logic pb;
    int k, n;
    wr(8'h14, {1'b0, mute, 2'h0, ms, fmt});
    repeat (3) bframe();
    repeat (4) @(posedge clk_i);
    push(w);
    bframe();
    chk(port_b_frame_clock_oe_o, ms);
    chk(port_b_bit_clock_oe_o, ms);
    cap = 25'h0;
    pb = port_b_bit_clock_i;
    k = 0;
    for (n = 0; n < 2000 && k < 25; n++)
    begin
      @(posedge clk_i);
      if (port_b_bit_clock_i && !pb)
      begin
        cap = {cap[23:0], port_b_serial_out_o};
        k++;
      end
      pb = port_b_bit_clock_i;
    end
    if (k < 25)
      hang();
    chk(cap, mute ? 25'h0 : fmt == 3'h1 ? {1'b0, w} : {w, 1'b0});
  endtask

  task automatic route();
    for (int i = 3; i >= 0; i--)
    begin
      wr(8'h14, {2'h0, i[1:0], 4'h0});
      @(posedge clk_i);
      chk({port_b_in_ready_o, port_a_in_ready_o, recv_ready_o}, 3'h4 >> i);
    end
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial
  begin
    n_fail = 0;
    total_checks = 0;
    rst_i = 1'b1;
    sl_run = 1'b0;
    {cyc_i, stb_i, we_i, port_b_in_valid_i, port_a_in_valid_i, recv_valid_i} = 6'h00;
    {adr_i, sel_i, dat_i} = 44'h0;
    {port_b_in_data_i, port_a_in_data_i, recv_data_i} = 75'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({port_a_frame_clock_oe_o, port_a_bit_clock_oe_o}, 2'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h14, 32'h0);
    rdc(8'h24, 32'h08);
    rdc(8'h3c, 32'h0);
    wr(8'h10, 8'hff);
    rdc(8'h10, 32'h0f);
    wr(8'h14, 8'hff);
    rdc(8'h14, 32'h7f);
    wb(8'h14, 1'b1, 4'h0, 32'h0, q);
    rdc(8'h14, 32'h7f);
    route();
    // Far side stalled: two words fill the buffer, a third is refused
    push(24'h111111);
    push(24'h222222);
    @(posedge clk_i);
    chk(port_b_in_ready_o, 1'b0);
    rdc(8'h24, 32'h04);
    wr(8'h20, 8'h01);
    for (int d = 0; d < 4; d++)
      aclk(2'h0, d[1:0], 10);
    aclk(2'h1, 2'h0, 12);
    aclk(2'h2, 2'h0, 14);
    wr(8'h10, 8'h0c);
    rdc(8'h24, 32'h04);
    wr(8'h10, 8'h00);
    sl_run <= 1'b1;
    ser(3'h0, 1'b0, 1'b1, 24'hc3a561);
    ser(3'h1, 1'b0, 1'b1, 24'h9e3b75);
    ser(3'h0, 1'b1, 1'b1, 24'hffffff);
    ser(3'h1, 1'b0, 1'b0, 24'h5a0f3c);
    test_done();
  end
endmodule

// File: src/apcf_fifo.sv
// Small valid/ready buffer sitting in the port B output data path
`timescale 1ns/1ps
module apcf_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign in_ready_o  = (count_ff != CW'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= bump(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= bump(rd_ptr_ff);
      count_ff <= CW'(count_ff + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data_i;
  end

endmodule

// File: src/apcf_pkg.sv
// Constants, field layouts and carrier types for the audio port clock and format control
// ---------------------------------------------------------------------------
// How it works
// - Port A clock register: bits 7:4 read zero, source in 3:2, divider in 1:0.
// - Master frame clock divides selected master clock by 128, 256, 384 or 512.
// - Master bit clock always runs at 64 times the frame clock.
// - Source codes pick main clock, receiver clock, recovered clock; code 11 reserved.
// - Port B register: bit 7 zero, mute 6, source 5:4, mode 3, format 2:0.
// - Format 000 is 24-bit left-justified, 001 is 24-bit I2S; 010, 011 unused.
// - Port B mode 0 takes clocks from outside; 1 derives them from port A source.
// - Port B output source: own input, port A input, receiver; 11 reserved.
// ---------------------------------------------------------------------------
package apcf_pkg;

  // -------------------------------------------------------------------------
  // Register map: printed index, byte address is four times the index
  // -------------------------------------------------------------------------
  localparam logic [5:0] APCF_IDX_A_CLK  = 6'h04;
  localparam logic [5:0] APCF_IDX_B_FMT  = 6'h05;
  localparam logic [5:0] APCF_IDX_A_MODE = 6'h08;
  localparam logic [5:0] APCF_IDX_STATUS = 6'h09;

  localparam logic [7:0] APCF_A_CLK_RST  = 8'h00;
  localparam logic [7:0] APCF_B_FMT_RST  = 8'h00;
  localparam logic [7:0] APCF_A_MODE_RST = 8'h00;

  // -------------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------------
  localparam int APCF_A_SRC_LSB  = 2;
  localparam int APCF_A_DIV_LSB  = 0;
  localparam int APCF_B_MUTE_BIT = 6;
  localparam int APCF_B_SRC_LSB  = 4;
  localparam int APCF_B_MS_BIT   = 3;
  localparam int APCF_B_FMT_LSB  = 0;
  localparam int APCF_A_MS_BIT   = 0;

  // Writable bits; the rest read as zero
  localparam logic [7:0] APCF_A_CLK_MASK  = 8'h0f;
  localparam logic [7:0] APCF_B_FMT_MASK  = 8'h7f;
  localparam logic [7:0] APCF_A_MODE_MASK = 8'h01;

  // -------------------------------------------------------------------------
  // Encodings
  // -------------------------------------------------------------------------
  localparam logic [1:0] APCF_SRC_MCLK  = 2'h0;
  localparam logic [1:0] APCF_SRC_RXCI  = 2'h1;
  localparam logic [1:0] APCF_SRC_RXCO  = 2'h2;
  localparam logic [1:0] APCF_SRC_RSVD  = 2'h3;

  localparam logic [1:0] APCF_OUT_LOOP  = 2'h0;
  localparam logic [1:0] APCF_OUT_PORTA = 2'h1;
  localparam logic [1:0] APCF_OUT_RECV  = 2'h2;

  localparam logic [2:0] APCF_FMT_LJ24  = 3'h0;
  localparam logic [2:0] APCF_FMT_I2S24 = 3'h1;

  // -------------------------------------------------------------------------
  // Counts: a divide code n gives a bit clock half period of n+1 master edges,
  // so the frame is 128 * (n+1) master cycles and the bit clock is 64 x frame
  // -------------------------------------------------------------------------
  localparam logic [5:0] APCF_HALF_BITS_LAST = 6'h3f;
  localparam logic [4:0] APCF_SLOT_LAST      = 5'h1f;
  localparam int         APCF_WORD_W         = 24;
  localparam int         APCF_BUF_DEPTH      = 2;

  typedef struct packed
  {
    logic        left;
    logic [23:0] data;
  } apcf_sample_t;

endpackage

// File: src/apcf_top.sv
// Audio port clock generation, port B format control and Wishbone registers
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module apcf_top #(
  parameter int ADR_W = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone classic slave
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [ADR_W-1:0]      adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  // Master clock candidates, sampled
  input  wire logic                  mclk_i,
  input  wire logic                  receiver_clock_in_i,
  input  wire logic                  recovered_receiver_clock_out_i,
  // Port A clock pins
  input  wire logic                  port_a_frame_clock_i,
  output logic                       port_a_frame_clock_o,
  output logic                       port_a_frame_clock_oe_o,
  input  wire logic                  port_a_bit_clock_i,
  output logic                       port_a_bit_clock_o,
  output logic                       port_a_bit_clock_oe_o,
  // Port B clock pins
  input  wire logic                  port_b_frame_clock_i,
  output logic                       port_b_frame_clock_o,
  output logic                       port_b_frame_clock_oe_o,
  input  wire logic                  port_b_bit_clock_i,
  output logic                       port_b_bit_clock_o,
  output logic                       port_b_bit_clock_oe_o,
  // Sample streams offered to port B output
  input  wire logic                  port_b_in_valid_i,
  output logic                       port_b_in_ready_o,
  input  wire apcf_pkg::apcf_sample_t port_b_in_data_i,
  input  wire logic                  port_a_in_valid_i,
  output logic                       port_a_in_ready_o,
  input  wire apcf_pkg::apcf_sample_t port_a_in_data_i,
  input  wire logic                  recv_valid_i,
  output logic                       recv_ready_o,
  input  wire apcf_pkg::apcf_sample_t recv_data_i,
  // Port B serial data
  output logic                       port_b_serial_out_o
);

  // -------------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------------
  logic [7:0] a_clk_ff;
  logic [7:0] b_fmt_ff;
  logic [7:0] a_mode_ff;

  wire [1:0] port_a_clock_source  = a_clk_ff[apcf_pkg::APCF_A_SRC_LSB +: 2];
  wire [1:0] port_a_divider_select = a_clk_ff[apcf_pkg::APCF_A_DIV_LSB +: 2];
  wire       port_b_mute           = b_fmt_ff[apcf_pkg::APCF_B_MUTE_BIT];
  wire [1:0] port_b_output_source  = b_fmt_ff[apcf_pkg::APCF_B_SRC_LSB +: 2];
  wire       port_b_master_slave   = b_fmt_ff[apcf_pkg::APCF_B_MS_BIT];
  wire [2:0] port_b_format_select  = b_fmt_ff[apcf_pkg::APCF_B_FMT_LSB +: 3];
  wire       port_a_master         = a_mode_ff[apcf_pkg::APCF_A_MS_BIT];

  // -------------------------------------------------------------------------
  // Wishbone slave: one wait state, unmapped words read zero and are acked
  // -------------------------------------------------------------------------
  logic        ack_ff;
  logic [31:0] rdata_ff;
  wire         req      = cyc_i && stb_i && !ack_ff;
  wire  [5:0]  word_idx = adr_i[7:2];
  wire         wr_lane0 = cyc_i && stb_i && ack_ff && we_i && sel_i[0];
  wire         hit_a    = (word_idx == apcf_pkg::APCF_IDX_A_CLK);
  wire         hit_b    = (word_idx == apcf_pkg::APCF_IDX_B_FMT);
  wire         hit_mode = (word_idx == apcf_pkg::APCF_IDX_A_MODE);
  wire         hit_stat = (word_idx == apcf_pkg::APCF_IDX_STATUS);
  wire  [7:0]  wdata    = dat_i[7:0];
  wire  [7:0]  status;
  wire  [7:0]  rd_byte;

  assign rd_byte = hit_a    ? a_clk_ff  :
                   hit_b    ? b_fmt_ff  :
                   hit_mode ? a_mode_ff :
                   hit_stat ? status    : 8'h00;

  assign ack_o = ack_ff;
  assign dat_o = rdata_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff   <= req;
      rdata_ff <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // A write lands on the edge where the master sees ack; reserved bits stay zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_clk_ff  <= apcf_pkg::APCF_A_CLK_RST;
      b_fmt_ff  <= apcf_pkg::APCF_B_FMT_RST;
      a_mode_ff <= apcf_pkg::APCF_A_MODE_RST;
    end
    else
    begin
      if (wr_lane0 && hit_a)
        a_clk_ff <= wdata & apcf_pkg::APCF_A_CLK_MASK;
      if (wr_lane0 && hit_b)
        b_fmt_ff <= wdata & apcf_pkg::APCF_B_FMT_MASK;
      if (wr_lane0 && hit_mode)
        a_mode_ff <= wdata & apcf_pkg::APCF_A_MODE_MASK;
    end
  end

  // -------------------------------------------------------------------------
  // Pin synchronisers; sampled clocks must stay below half of clk_i
  // -------------------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] pins;

  assign pins = {port_b_bit_clock_i, port_b_frame_clock_i, port_a_bit_clock_i,
                 port_a_frame_clock_i, recovered_receiver_clock_out_i,
                 receiver_clock_in_i, mclk_i};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  wire ext_b_bit   = sync2_ff[6];
  wire ext_b_frame = sync2_ff[5];

  // -------------------------------------------------------------------------
  // Master clock selection and frame/bit clock divider
  // -------------------------------------------------------------------------
  logic       src_prev_ff;
  logic [1:0] edge_cnt_ff;
  logic [5:0] half_cnt_ff;
  logic       gen_bit_ff;
  logic       gen_frame_ff;
  logic       src_lvl;

  always_comb
  begin
    case (port_a_clock_source)
      apcf_pkg::APCF_SRC_MCLK: src_lvl = sync2_ff[0];
      apcf_pkg::APCF_SRC_RXCI: src_lvl = sync2_ff[1];
      apcf_pkg::APCF_SRC_RXCO: src_lvl = sync2_ff[2];
      default:                 src_lvl = 1'b0;
    endcase
  end

  // Port A source and divider only matter when some port is master
  wire gen_run   = (port_a_master || port_b_master_slave) &&
                   (port_a_clock_source != apcf_pkg::APCF_SRC_RSVD);
  wire src_rise  = gen_run && src_lvl && !src_prev_ff;
  wire half_done = src_rise && (edge_cnt_ff == port_a_divider_select);
  wire frame_flip = half_done && (half_cnt_ff == apcf_pkg::APCF_HALF_BITS_LAST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !gen_run)
    begin
      src_prev_ff  <= 1'b0;
      edge_cnt_ff  <= 2'h0;
      half_cnt_ff  <= 6'h00;
      gen_bit_ff   <= 1'b0;
      gen_frame_ff <= 1'b0;
    end
    else
    begin
      src_prev_ff <= src_lvl;
      if (half_done)
        edge_cnt_ff <= 2'h0;
      else if (src_rise)
        edge_cnt_ff <= edge_cnt_ff + 2'h1;
      if (half_done)
      begin
        gen_bit_ff  <= !gen_bit_ff;
        half_cnt_ff <= half_cnt_ff + 6'h01;
      end
      if (frame_flip)
        gen_frame_ff <= !gen_frame_ff;
    end
  end

  // -------------------------------------------------------------------------
  // Clock pins: driven only in master mode, otherwise left to the far end
  // -------------------------------------------------------------------------
  assign port_a_frame_clock_o    = gen_frame_ff;
  assign port_a_bit_clock_o      = gen_bit_ff;
  assign port_a_frame_clock_oe_o = port_a_master;
  assign port_a_bit_clock_oe_o   = port_a_master;
  assign port_b_frame_clock_o    = gen_frame_ff;
  assign port_b_bit_clock_o      = gen_bit_ff;
  assign port_b_frame_clock_oe_o = port_b_master_slave;
  assign port_b_bit_clock_oe_o   = port_b_master_slave;

  wire b_bit   = port_b_master_slave ? gen_bit_ff   : ext_b_bit;
  wire b_frame = port_b_master_slave ? gen_frame_ff : ext_b_frame;

  // -------------------------------------------------------------------------
  // Output source selection into the buffer
  // -------------------------------------------------------------------------
  apcf_pkg::apcf_sample_t sel_data;
  apcf_pkg::apcf_sample_t buf_data;
  logic                   sel_valid;
  logic                   buf_in_ready;
  logic                   buf_valid;
  logic                   buf_pop;

  wire src_loop = (port_b_output_source == apcf_pkg::APCF_OUT_LOOP);
  wire src_pa   = (port_b_output_source == apcf_pkg::APCF_OUT_PORTA);
  wire src_rx   = (port_b_output_source == apcf_pkg::APCF_OUT_RECV);

  // Reserved code picks nothing, so no source sees ready
  assign sel_valid = (src_loop && port_b_in_valid_i) ||
                     (src_pa && port_a_in_valid_i) ||
                     (src_rx && recv_valid_i);
  assign sel_data  = src_pa ? port_a_in_data_i :
                     src_rx ? recv_data_i : port_b_in_data_i;
  assign port_b_in_ready_o = src_loop && buf_in_ready;
  assign port_a_in_ready_o = src_pa && buf_in_ready;
  assign recv_ready_o      = src_rx && buf_in_ready;

  apcf_fifo #(
    .WIDTH ($bits(apcf_pkg::apcf_sample_t)),
    .DEPTH (apcf_pkg::APCF_BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (sel_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (sel_data),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_data)
  );

  // -------------------------------------------------------------------------
  // Port B serialiser: data changes on the bit clock falling edge
  // -------------------------------------------------------------------------
  logic        bit_prev_ff;
  logic        frame_seen_ff;
  logic [4:0]  slot_ff;
  logic [23:0] word_ff;
  logic        sdo_ff;

  function automatic logic pick_bit(input logic [23:0] w, input logic [4:0] slot,
                                    input logic i2s);
    logic [4:0] pos;
    pos = i2s ? 5'(slot - 5'h01) : slot;
    if (i2s && slot == 5'h00)
      pick_bit = 1'b0;
    else if (pos < 5'(apcf_pkg::APCF_WORD_W))
      pick_bit = w[5'(apcf_pkg::APCF_WORD_W - 1) - pos];
    else
      pick_bit = 1'b0;
  endfunction

  wire        bit_fall  = bit_prev_ff && !b_bit;
  wire        new_slot  = bit_fall && (b_frame != frame_seen_ff);
  wire        fmt_i2s   = (port_b_format_select == apcf_pkg::APCF_FMT_I2S24);
  // Unused codes fall back to left-justified rather than stopping output
  wire [4:0]  nxt_slot  = new_slot ? 5'h00 :
                          (slot_ff == apcf_pkg::APCF_SLOT_LAST) ? slot_ff : 5'(slot_ff + 5'h01);
  // An empty buffer at a frame edge sends a zero word instead of stale data
  wire [23:0] nxt_word  = new_slot ? (buf_valid ? buf_data.data : 24'h00_0000) : word_ff;
  wire        nxt_sdo   = pick_bit(nxt_word, nxt_slot, fmt_i2s);

  assign buf_pop = new_slot && buf_valid;
  assign port_b_serial_out_o = sdo_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_prev_ff   <= 1'b0;
      frame_seen_ff <= 1'b0;
      slot_ff       <= apcf_pkg::APCF_SLOT_LAST;
      word_ff       <= 24'h00_0000;
      sdo_ff        <= 1'b0;
    end
    else
    begin
      bit_prev_ff <= b_bit;
      if (bit_fall)
      begin
        frame_seen_ff <= b_frame;
        slot_ff       <= nxt_slot;
        word_ff       <= nxt_word;
        sdo_ff        <= nxt_sdo && !port_b_mute;
      end
      else if (port_b_mute)
        sdo_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Status: generator clocks and buffer levels, all from flops or the buffer
  // -------------------------------------------------------------------------
  assign status = {4'h0, buf_in_ready, buf_valid, gen_frame_ff, gen_bit_ff};

endmodule
